// >>> core/uoe_ep_reg.v
// Purpose: Control register state of one non-zero OUT endpoint.
// Assumes: Write strobe is a full-word APB write that completes this cycle.
// Notes: Command bits are not stored and read back as zero.
`timescale 1ns/1ns
`include "uoe_defs.vh"
module uoe_ep_reg (
  input wire pclk,
  input wire presetn,
  input wire wr_en,
  input wire [31:0] wdata,
  input wire setup_rx,
  input wire disable_done,
  input wire xfer_done,
  input wire data_rx_ok,
  output wire [31:0] rd_val,
  output reg en_ff,
  output reg dis_ff,
  output reg stall_ff,
  output reg snoop_ff,
  output reg [1:0] type_ff,
  output reg nak_state_ff,
  output reg par_ff,
  output reg act_ff,
  output reg [10:0] mpl_ff
);
  wire iso = (type_ff == `UOE_TYPE_ISO);
  wire ctl = (type_ff == `UOE_TYPE_CTRL);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_ff <= 1'b0;
      dis_ff <= 1'b0;
      stall_ff <= 1'b0;
      snoop_ff <= 1'b0;
      type_ff <= `UOE_TYPE_CTRL;
      nak_state_ff <= 1'b0;
      par_ff <= 1'b0;
      act_ff <= 1'b0;
      mpl_ff <= 11'h000;
    end else begin
      // Device clears enable when the disable ends or a transfer completes; software cannot clear it.
      if (disable_done || xfer_done) begin
        en_ff <= 1'b0;
      end else if (wr_en && wdata[`UOE_BIT_EN]) begin
        en_ff <= 1'b1;
      end
      if (disable_done) begin
        dis_ff <= 1'b0;
      end else if (wr_en && wdata[`UOE_BIT_DIS] && en_ff) begin
        dis_ff <= 1'b1;
      end
      if (wr_en) begin
        snoop_ff <= wdata[`UOE_BIT_SNOOP];
        type_ff <= wdata[`UOE_TYPE_HI:`UOE_TYPE_LO];
        act_ff <= wdata[`UOE_BIT_ACT];
        mpl_ff <= wdata[`UOE_MPL_HI:`UOE_MPL_LO];
      end
      // Set wins over a same-cycle clear by SETUP or by software.
      if (wr_en && wdata[`UOE_BIT_STALL]) begin
        stall_ff <= 1'b1;
      end else if (ctl && setup_rx) begin
        stall_ff <= 1'b0;
      end else if (wr_en && !ctl) begin
        stall_ff <= 1'b0;
      end
      if (wr_en && wdata[`UOE_BIT_NAK_SET_CMD]) begin
        nak_state_ff <= 1'b1;
      end else if (wr_en && wdata[`UOE_BIT_NAK_CLEAR_CMD]) begin
        nak_state_ff <= 1'b0;
      end
      if (wr_en && wdata[`UOE_BIT_SET1]) begin
        par_ff <= 1'b1;
      end else if (wr_en && wdata[`UOE_BIT_SET0]) begin
        par_ff <= 1'b0;
      end else if (data_rx_ok && !iso) begin
        par_ff <= ~par_ff;
      end
    end
  end
  // Frame parity and toggle share one bit; the type decides its meaning.
  assign rd_val = {en_ff, dis_ff, 4'h0, 4'h0, stall_ff, snoop_ff, type_ff, nak_state_ff,
    par_ff, act_ff, 4'h0, mpl_ff};
endmodule // uoe_ep_reg

// >>> core/uoe_out_ep_ctrl.v
// Purpose: APB register block and handshake choice for OUT endpoints 1 to 3.
// Assumes: Link events arrive on pclk as one-cycle pulses with an endpoint index.
// Notes: Partial-word writes are refused with pslverr.
//
// Operation
// - Registers at base plus endpoint times 0x20.
// - All register bits zero after reset.
// - Only full 32-bit word accesses allowed.
// - Software sets enable; only device clears it.
// - Writing disable to an enabled endpoint starts disabling it.
// - Isochronous set-odd command sets frame parity.
// - Bulk/interrupt set-data1 command sets toggle.
// - Isochronous set-even command clears frame parity.
// - Bulk/interrupt set-data0 command clears toggle.
// - Set-NAK command sets NAK state.
// - Clear-NAK command clears NAK state.
// - Stall answers OUT, beats both Nak_state.
// - Control endpoint: SETUP clears stall, software cannot.
// - Bulk/interrupt: only software clears stall.
// - Snoop bit disables CRC check.
// - Type field: control, iso, bulk, interrupt.
// - NAK state forces NAK, else FIFO status.
// - Low eleven bits hold max packet length.
// - Inactive endpoint ignores tokens, no response.
`timescale 1ns/1ns
`include "uoe_defs.vh"
module uoe_out_ep_ctrl #(
  parameter NUM_EP = 3
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire global_out_nak_state,
  input wire global_in_nak,
  input wire tok_valid,
  input wire tok_setup,
  input wire [1:0] tok_ep,
  input wire rx_fifo_room,
  input wire crc_ok,
  input wire disable_done,
  input wire xfer_done,
  output reg [3:0] hs_code_ff,
  output reg hs_valid_ff,
  output wire [NUM_EP-1:0] endpoint_enable_bit,
  output wire [NUM_EP-1:0] endpoint_disable_cmd,
  output wire [NUM_EP-1:0] snoop_mode
);
  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire [31:0] rd_val [0:NUM_EP];
  wire [NUM_EP:1] hit;
  wire any_hit = |hit;
  wire full_word = (pstrb == 4'hf) || !pwrite;
  wire acc = psel && penable;
  wire wr_ok = acc && pwrite && any_hit && full_word;
  wire [NUM_EP:1] stall_v;
  wire [NUM_EP:1] nak_state_v;
  wire [NUM_EP:1] act_v;
  wire [NUM_EP:1] snoop_v;
  wire [NUM_EP:1] par_v;
  wire [1:0] type_v [1:NUM_EP];
  // Endpoint of the previous token, so an ACK can flip the right toggle.
  reg [1:0] last_ep_ff;
  // Single-cycle access phase keeps the slave simple and fast.
  assign pready = 1'b1;
  assign pslverr = acc && (!any_hit || !full_word);
  assign rd_val[0] = `UOE_RESET_VAL;
  genvar g;
  generate
    for (g = 1; g <= NUM_EP; g = g + 1) begin : g_ep
      localparam [1:0] EP_IDX = g;
      localparam [`UOE_ADDR_W-1:0] EP_ADDR = `UOE_BASE_ADDR + EP_IDX * `UOE_STRIDE;
      assign hit[g] = (paddr == EP_ADDR);
      uoe_ep_reg u_reg (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_ok && hit[g]),
        .wdata(pwdata),
        .setup_rx(tok_valid && tok_setup && (tok_ep == EP_IDX) && act_v[g]),
        .disable_done(disable_done && (tok_ep == EP_IDX)),
        .xfer_done(xfer_done && (tok_ep == EP_IDX)),
        .data_rx_ok(hs_valid_ff && (hs_code_ff == `UOE_HS_ACK) && (last_ep_ff == EP_IDX)),
        .rd_val(rd_val[g]),
        .en_ff(endpoint_enable_bit[g-1]),
        .dis_ff(endpoint_disable_cmd[g-1]),
        .stall_ff(stall_v[g]),
        .snoop_ff(snoop_v[g]),
        .type_ff(type_v[g]),
        .nak_state_ff(nak_state_v[g]),
        .par_ff(par_v[g]),
        .act_ff(act_v[g]),
        .mpl_ff()
      );
      assign snoop_mode[g-1] = snoop_v[g];
    end
  endgenerate
  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  integer i;
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    for (i = 1; i <= NUM_EP; i = i + 1) begin
      if (hit[i]) begin
        rd_mux = rd_val[i];
      end
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end
  // ----------------------------------------------------------------
  // Handshake choice for an OUT data packet
  // ----------------------------------------------------------------
  integer j;
  reg [3:0] nxt_hs;
  reg [NUM_EP:1] ep_sel;
  reg sel_stall, sel_nak_state, sel_act, sel_snoop;
  always @* begin
    ep_sel = {NUM_EP{1'b0}};
    sel_stall = 1'b0;
    sel_nak_state = 1'b0;
    sel_act = 1'b0;
    sel_snoop = 1'b0;
    for (j = 1; j <= NUM_EP; j = j + 1) begin
      if (tok_ep == j[1:0]) begin
        ep_sel[j] = 1'b1;
        sel_stall = stall_v[j];
        sel_nak_state = nak_state_v[j];
        sel_act = act_v[j];
        sel_snoop = snoop_v[j];
      end
    end
    if (!sel_act || tok_setup) begin
      nxt_hs = `UOE_HS_NONE;
    end else if (sel_stall) begin
      nxt_hs = `UOE_HS_STALL;
    end else if (global_out_nak_state || global_in_nak || sel_nak_state) begin
      nxt_hs = `UOE_HS_NAK;
    end else if (!crc_ok && !sel_snoop) begin
      nxt_hs = `UOE_HS_NONE;
    end else if (rx_fifo_room) begin
      nxt_hs = `UOE_HS_ACK;
    end else begin
      nxt_hs = `UOE_HS_NAK;
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_code_ff <= `UOE_HS_NONE;
      hs_valid_ff <= 1'b0;
      last_ep_ff <= 2'b00;
    end else begin
      hs_valid_ff <= tok_valid && (|ep_sel);
      hs_code_ff <= nxt_hs;
      last_ep_ff <= tok_ep;
    end
  end
endmodule // uoe_out_ep_ctrl

// >>> pkg/uoe_defs.vh
// Purpose: Constants for the OUT endpoint control register block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Endpoints 1 to 3 sit at base plus endpoint number times stride.
`ifndef UOE_DEFS_VH
`define UOE_DEFS_VH
`define UOE_BASE_ADDR 12'h0b00
`define UOE_STRIDE 12'h0020
`define UOE_ADDR_W 12
`define UOE_RESET_VAL 32'h0000_0000
`define UOE_BIT_EN 31
`define UOE_BIT_DIS 30
`define UOE_BIT_SET1 29
`define UOE_BIT_SET0 28
`define UOE_BIT_NAK_SET_CMD 27
`define UOE_BIT_NAK_CLEAR_CMD 26
`define UOE_BIT_STALL 21
`define UOE_BIT_SNOOP 20
`define UOE_TYPE_HI 19
`define UOE_TYPE_LO 18
`define UOE_BIT_NAK_STATE 17
`define UOE_BIT_PAR 16
`define UOE_BIT_ACT 15
`define UOE_MPL_HI 10
`define UOE_MPL_LO 0
`define UOE_TYPE_CTRL 2'b00
`define UOE_TYPE_ISO 2'b01
`define UOE_TYPE_BULK 2'b10
`define UOE_TYPE_INTR 2'b11
`define UOE_HS_NONE 4'b0001
`define UOE_HS_ACK 4'b0010
`define UOE_HS_NAK 4'b0100
`define UOE_HS_STALL 4'b1000
`endif

// >>> sim/uoe_host_model.sv
// Purpose: Host side that sends tokens and link events.
// Assumes: Handshake comes one cycle after the token.
// Notes: Released strobes return to zero; released tok_ep, tok_setup and crc_ok show inverted values so stale data is never mistaken for fresh.
`timescale 1ns/1ns
module uoe_host_model (
  input wire pclk,
  input wire hs_valid_ff,
  input wire [3:0] hs_code_ff,
  output logic tok_valid = 0, output logic tok_setup = 0, output logic [1:0] tok_ep = 0,
  output logic crc_ok = 1, output logic disable_done = 0, output logic xfer_done = 0
);
  task ev(input [1:0] p, input [3:0] k, input c, output [3:0] h);
    @(posedge pclk);
    {xfer_done, disable_done, tok_setup, tok_valid} <= k;
    tok_ep <= p;
    crc_ok <= c;
    @(posedge pclk);
    {xfer_done, disable_done, tok_valid} <= 3'h0;
    {tok_ep, tok_setup, crc_ok} <= ~{p, k[1], c};
    @(negedge pclk);
    h = hs_valid_ff ? hs_code_ff : 4'h0;
  endtask
endmodule // uoe_host_model

// >>> sim/uoe_out_ep_ctrl_properties.sv
// Purpose: Port checks for the OUT endpoint control block.
// Assumes: One clock domain, reset active low.
// Notes: Handshake codes are one-hot, 0010 is ACK.
`timescale 1ns/1ns
module uoe_out_ep_ctrl_properties #(parameter NUM_EP = 3) (
  input wire pclk, input wire presetn, input wire psel, input wire penable,
  input wire pwrite, input wire [11:0] paddr, input wire [31:0] pwdata,
  input wire [3:0] pstrb, input wire pslverr, input wire tok_valid, input wire tok_setup,
  input wire [1:0] tok_ep, input wire crc_ok, input wire rx_fifo_room,
  input wire global_out_nak_state, input wire disable_done, input wire [3:0] hs_code_ff,
  input wire hs_valid_ff, input wire [NUM_EP-1:0] endpoint_enable_bit,
  input wire [NUM_EP-1:0] endpoint_disable_cmd, input wire [NUM_EP-1:0] snoop_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire tk = tok_valid && tok_ep != 2'h0;
  a_bad_strobe: assert property (acc && pwrite && pstrb != 4'hf |-> pslverr)
    else $error("partial write not refused");
  a_unmapped_addr: assert property (acc && !(paddr inside {12'hb20, 12'hb40, 12'hb60})
    |-> pslverr) else $error("unmapped access not refused");
  a_hs_follows: assert property (tk |=> hs_valid_ff) else $error("no handshake");
  a_setup_silent: assert property (tk && tok_setup |=> hs_code_ff == 4'h1)
    else $error("setup answered");
  a_gnak_blocks: assert property (tk && global_out_nak_state |=> hs_code_ff != 4'h2)
    else $error("ack under global nak");
  a_room_needed: assert property (tk && !rx_fifo_room |=> hs_code_ff != 4'h2)
    else $error("ack with full fifo");
  a_crc_drop: assert property (tk && !crc_ok && !snoop_mode[tok_ep - 2'h1]
    |=> hs_code_ff != 4'h2) else $error("bad crc acked");
  a_en_by_sw: assert property ((endpoint_enable_bit & ~$past(endpoint_enable_bit)) != 0
    |-> $past(acc && pwrite && pwdata[31])) else $error("enable set by device");
  a_dis_done: assert property (disable_done && tok_ep == 2'h3
    |=> !endpoint_enable_bit[2] && !endpoint_disable_cmd[2]) else $error("disable stuck");
endmodule // uoe_out_ep_ctrl_properties

// >>> sim/uoe_out_ep_ctrl_tb.sv
// Purpose: Random and corner tests of the OUT endpoint control block.
// Assumes: Zero wait states, handshake one cycle after a token.
// Notes: Expected words are built from field positions.
`timescale 1ns/1ns
`define CHK(g, x) begin total_checks++; if ((g) !== (x)) begin n_mismatch++; \
  $display("[ERR] t=%0t got %h exp %h", $time, g, x); end end
module uoe_out_ep_ctrl_tb;
  localparam NUM_EP = 3;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, r, w, b;
  logic [3:0] pstrb = 0, h;
  logic rx_fifo_room = 1, global_out_nak_state = 0, global_in_nak = 0;
  wire pready, pslverr, tok_valid, tok_setup, crc_ok, disable_done, xfer_done, hs_valid_ff;
  wire [31:0] prdata;
  wire [1:0] tok_ep;
  wire [3:0] hs_code_ff;
  wire [NUM_EP-1:0] endpoint_enable_bit, endpoint_disable_cmd, snoop_mode;
  integer seed = 29677, n_mismatch = 0, total_checks = 0, i, k;
  always #5 pclk = ~pclk;
  uoe_out_ep_ctrl #(.NUM_EP(NUM_EP)) uoe_out_ep_ctrl_inst (.*);
  uoe_host_model uoe_host_model_inst (.*);
  function [31:0] cf(input [1:0] t, input [10:0] m);
    cf = {12'h0, t, 2'h0, 1'b1, 4'h0, m};
  endfunction
  task apb(input x, input [11:0] a, input [31:0] d, input [3:0] s);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, x, a, d, s};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task wr(input [1:0] p, input [31:0] d);
    apb(1'b1, 12'hb00 + {p, 5'h0}, d, 4'hf);
  endtask
  task rd(input [1:0] p);
    apb(1'b0, 12'hb00 + {p, 5'h0}, 32'h0, 4'hf);
  endtask
  task tk(input [1:0] p, input [3:0] k, input c, input [3:0] x);
    uoe_host_model_inst.ev(p, k, c, h);
    `CHK(h, x)
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    end_of_test;
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 1; i < 4; i++) begin
      rd(i);
      `CHK(r, 32'h0)
    end
    apb(1'b0, 12'hb00, 32'h0, 4'hf);
    `CHK({e, r}, 33'h1_0000_0000)
    $display("reset test done");
    for (i = 1; i < 4; i++) begin
      r = $random(seed);
      w = cf(i[1:0], r[10:0]) | 32'h8010_0000;
      for (k = 0; k < 4; k++) begin
        wr(i, w | (32'h2000_0000 >> k));
        rd(i);
        `CHK(r, w | (k == 0 ? 32'h1_0000 : k == 2 ? 32'h2_0000 : 32'h0))
      end
    end
    `CHK({endpoint_enable_bit, snoop_mode}, 6'h3f)
    apb(1'b1, 12'hb60, 32'h0, 4'h3);
    `CHK(e, 1'b1)
    rd(3);
    `CHK(r, w)
    wr(3, w | 32'h4000_0000);
    @(negedge pclk);
    `CHK(endpoint_disable_cmd, 3'h4)
    uoe_host_model_inst.ev(2'h3, 4'h4, 1'b1, h);
    `CHK({endpoint_enable_bit[2], endpoint_disable_cmd}, 4'h0)
    $display("register test done");
    b = cf(2'h2, 11'h040) | 32'h8000_0000;
    wr(1, b);
    tk(1, 4'h1, 1'b1, 4'h2);
    wr(1, b | 32'h0800_0000);
    tk(1, 4'h1, 1'b1, 4'h4);
    wr(1, b | 32'h0020_0000);
    global_in_nak <= 1'b1;
    tk(1, 4'h1, 1'b1, 4'h8);
    wr(1, b | 32'h0400_0000);
    global_in_nak <= 1'b0;
    tk(1, 4'h1, 1'b1, 4'h2);
    wr(1, b);
    global_out_nak_state <= 1'b1;
    tk(1, 4'h1, 1'b1, 4'h4);
    wr(1, b);
    {global_out_nak_state, rx_fifo_room} <= 2'b00;
    tk(1, 4'h1, 1'b1, 4'h4);
    wr(1, b);
    rx_fifo_room <= 1'b1;
    tk(1, 4'h1, 1'b0, 4'h1);
    wr(1, b | 32'h0010_0000);
    tk(1, 4'h1, 1'b0, 4'h2);
    wr(2, cf(2'h0, 11'h040) | 32'h8020_0000);
    tk(2, 4'h1, 1'b1, 4'h8);
    wr(2, cf(2'h0, 11'h040) | 32'h8000_0000);
    rd(2);
    `CHK(r[21], 1'b1)
    tk(2, 4'h3, 1'b1, 4'h1);
    rd(2);
    `CHK(r[21], 1'b0)
    wr(3, b ^ 32'h0000_8000);
    tk(3, 4'h1, 1'b1, 4'h1);
    uoe_host_model_inst.ev(2'h3, 4'h8, 1'b1, h);
    `CHK(endpoint_enable_bit[2], 1'b0)
    $display("handshake test done");
    end_of_test;
  end
endmodule // uoe_out_ep_ctrl_tb
bind uoe_out_ep_ctrl uoe_out_ep_ctrl_properties #(.NUM_EP(NUM_EP)) chk_inst (.*);
